// file: ddsc_ctrl.sv
// Serial command decoder and register file of a dual 16-bit converter.
// Assumes all link pins are asynchronous to i_sys_clk and are oversampled.
// Overview of operation
// [RULE1] Host enables readback output before reading
// [RULE2] Read flag set: enter read, write nothing
// [RULE3] Read picks target and channel, ignores data
// [RULE4] Next frame shifts chosen register out
// [RULE5] Host sends no-operation word to collect
// [RULE6] Fine gain returned in lowest six bits
// [RULE7] Load low while shifting: update on frame end
// [RULE8] Load high then falling: update all channels
// [RULE9] Clear falling edge forces outputs to clear
// [RULE10] Outputs stay cleared until reprogrammed
// [RULE11] Clear low at power-on loads clear value
// [RULE12] Function write, channel 100, clears outputs
// [RULE13] Word MSB is the read flag
// [RULE14] Target field selects function/data/gains/offset
// [RULE15] Channel field: A, B, both, else none
// [RULE16] 24 bits MSB first; other counts invalid
// [RULE17] Readback changes on rising shift edges
// [RULE18] Host sends reserved bit as zero
// [RULE19] Output-disable bit gates readback output
`timescale 1ns/10ps
module ddsc_ctrl #(
  parameter int unsigned FRAME_BITS = ddsc_pkg::DDSC_FRAME_BITS
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_shift_clk,
  input wire logic i_frame_sel_n,
  input wire logic i_shift_data_in,
  input wire logic i_output_load_n,
  input wire logic i_async_zero_n,
  input wire logic i_coding_select,
  output logic o_serial_readback_out,
  output logic o_serial_readback_oe,
  output ddsc_pkg::ddsc_chan_t o_chan_a,
  output ddsc_pkg::ddsc_chan_t o_chan_b,
  output logic [15:0] o_dac_a,
  output logic [15:0] o_dac_b,
  output logic [5:0] o_func_ctrl,
  output logic o_frame_error
);
  import ddsc_pkg::*;

  initial begin
    if (FRAME_BITS != DDSC_FRAME_BITS) $error("FRAME_BITS must match the command word width");
  end

  // Three-stage samplers; a change counts once stages two and three agree
  logic [2:0] sclk_s_q, sync_s_q, sdi_s_q, output_load_n_s_q, clr_s_q, cod_s_q;
  logic sclk_q, sync_q, output_load_n_q, clr_q, cod_q;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sclk_s_q <= 3'h7;
      sync_s_q <= 3'h7;
      sdi_s_q <= 3'h0;
      output_load_n_s_q <= 3'h7;
      clr_s_q <= 3'h7;
      cod_s_q <= 3'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], i_shift_clk};
      sync_s_q <= {sync_s_q[1:0], i_frame_sel_n};
      sdi_s_q <= {sdi_s_q[1:0], i_shift_data_in};
      output_load_n_s_q <= {output_load_n_s_q[1:0], i_output_load_n};
      clr_s_q <= {clr_s_q[1:0], i_async_zero_n};
      cod_s_q <= {cod_s_q[1:0], i_coding_select};
    end
  end

  function automatic logic filt(input logic [2:0] s, input logic prev);
    filt = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  wire sclk_d = filt(sclk_s_q, sclk_q);
  wire sync_d = filt(sync_s_q, sync_q);
  wire output_load_n_d = filt(output_load_n_s_q, output_load_n_q);
  wire clr_d = filt(clr_s_q, clr_q);
  wire cod_d = filt(cod_s_q, cod_q);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      // Idle level of the shift clock is high; avoids a false rise after reset
      sclk_q <= 1'b1;
      sync_q <= 1'b1;
      output_load_n_q <= 1'b1;
      clr_q <= 1'b1;
      cod_q <= 1'b0;
    end else begin
      sclk_q <= sclk_d;
      sync_q <= sync_d;
      output_load_n_q <= output_load_n_d;
      clr_q <= clr_d;
      cod_q <= cod_d;
    end
  end

  wire sclk_fall = sclk_q & ~sclk_d;
  wire sclk_rise = ~sclk_q & sclk_d;
  wire frame_start = sync_q & ~sync_d;
  wire frame_end = ~sync_q & sync_d;
  wire in_frame = ~sync_q;
  wire output_load_n_fall = output_load_n_q & ~output_load_n_d;
  wire clr_fall = clr_q & ~clr_d;

  // Shift register and edge counter
  logic [23:0] shift_q;
  logic [5:0] bitcnt_q;
  logic output_load_n_frame_low_q;
  wire [5:0] frame_bits_c = 6'(FRAME_BITS);
  wire bit_take = in_frame & sclk_fall;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift_q <= 24'h000000;
      bitcnt_q <= 6'h00;
      output_load_n_frame_low_q <= 1'b0;
    end else if (frame_start) begin
      bitcnt_q <= 6'h00;
      output_load_n_frame_low_q <= 1'b0;
    end else if (bit_take) begin
      shift_q <= {shift_q[22:0], sdi_s_q[2]}; // [RULE16]
      if (bitcnt_q != 6'h3f) bitcnt_q <= bitcnt_q + 6'h01;
      output_load_n_frame_low_q <= output_load_n_frame_low_q | ~output_load_n_q;
    end else if (in_frame && !output_load_n_q) begin
      output_load_n_frame_low_q <= 1'b1;
    end
  end

  // Decode of the completed word
  ddsc_cmd_t cmd;
  assign cmd = ddsc_cmd_t'(shift_q);
  wire frame_ok = frame_end & (bitcnt_q == frame_bits_c); // [RULE16]
  wire is_read = cmd.rd; // [RULE13]
  wire do_write = frame_ok & ~is_read; // [RULE2]
  // [RULE15]
  wire sel_a = (cmd.chn == DDSC_CHN_A) | (cmd.chn == DDSC_CHN_BOTH);
  wire sel_b = (cmd.chn == DDSC_CHN_B) | (cmd.chn == DDSC_CHN_BOTH);
  wire tgt_func = cmd.tgt == DDSC_TGT_FUNC; // [RULE14]
  wire wr_data = do_write & (cmd.tgt == DDSC_TGT_DATA);
  wire wr_cg = do_write & (cmd.tgt == DDSC_TGT_CGAIN);
  wire wr_fg = do_write & (cmd.tgt == DDSC_TGT_FGAIN);
  wire wr_of = do_write & (cmd.tgt == DDSC_TGT_OFFS);
  wire wr_fn = do_write & tgt_func & (cmd.chn == DDSC_FN_CTRL);
  wire sw_clear = do_write & tgt_func & (cmd.chn == DDSC_FN_CLEAR); // [RULE12]
  wire sw_load = do_write & tgt_func & (cmd.chn == DDSC_FN_LOAD);
  wire ind_load = wr_data & output_load_n_frame_low_q; // [RULE7]
  wire all_load = output_load_n_fall & sync_q | sw_load; // [RULE8]
  wire clear_ev = clr_fall | sw_clear; // [RULE9]
  wire [15:0] clr_code = cod_q ? DDSC_CLR_BIN : DDSC_CLR_TWOS;

  // Function control bits; output-disable bit resets to 0, so readback output defaults to enabled
  logic [5:0] func_q;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) func_q <= DDSC_FN_RST;
    else if (wr_fn) func_q <= cmd.data[DDSC_FN_W-1:0];
  end

  // Per-channel input registers and outputs
  ddsc_chan_t chan_q [2];
  logic [15:0] dac_q [2];
  logic por_chk_q;
  wire [1:0] sel_v = {sel_b, sel_a};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          chan_q[g] <= '0;
        end else if (sel_v[g]) begin
          if (wr_data) chan_q[g].data <= cmd.data;
          if (wr_cg) chan_q[g].cgain <= cmd.data[DDSC_CG_W-1:0];
          if (wr_fg) chan_q[g].fgain <= cmd.data[DDSC_FG_W-1:0];
          if (wr_of) chan_q[g].offs <= cmd.data[DDSC_OFS_W-1:0];
        end
      end
      // Clear takes priority; held until a later load reprograms the output
      always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) dac_q[g] <= DDSC_DATA_RST;
        else if (clear_ev || (por_chk_q && !clr_q)) dac_q[g] <= clr_code; // [RULE9] [RULE11]
        else if (all_load) dac_q[g] <= chan_q[g].data; // [RULE8] [RULE10]
        else if (ind_load && sel_v[g]) dac_q[g] <= cmd.data; // [RULE7]
      end
    end
  endgenerate

  // Power-on clear check once the clear pin has been sampled stably
  logic [2:0] por_cnt_q;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      por_cnt_q <= 3'h0;
      por_chk_q <= 1'b0;
    end else begin
      if (por_cnt_q != 3'h5) por_cnt_q <= por_cnt_q + 3'h1;
      por_chk_q <= (por_cnt_q == 3'h4);
    end
  end

  // Readback selection
  function automatic logic [15:0] rd_sel(input logic [2:0] t, input ddsc_chan_t c,
                                         input logic [5:0] f);
    case (t)
      DDSC_TGT_FUNC: rd_sel = {10'h000, f};
      DDSC_TGT_DATA: rd_sel = c.data;
      DDSC_TGT_CGAIN: rd_sel = {14'h0000, c.cgain};
      DDSC_TGT_FGAIN: rd_sel = {10'h000, c.fgain}; // [RULE6]
      DDSC_TGT_OFFS: rd_sel = {8'h00, c.offs};
      default: rd_sel = 16'h0000;
    endcase
  endfunction

  // Channel B only when the read names B alone; [RULE3]
  wire [15:0] rd_word = rd_sel(cmd.tgt, (cmd.chn == DDSC_CHN_B) ? chan_q[1] : chan_q[0], func_q);

  // Readback word armed by a valid read, shifted on the next frame
  logic [23:0] rb_q;
  logic rb_arm_q;
  logic sdo_q;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rb_q <= 24'h000000;
      rb_arm_q <= 1'b0;
      sdo_q <= 1'b0;
    end else if (frame_ok && is_read) begin
      rb_q <= {8'h00, rd_word}; // [RULE2] [RULE3]
      rb_arm_q <= 1'b1;
    end else if (frame_end) begin
      rb_arm_q <= 1'b0;
      rb_q <= 24'h000000;
    end else if (frame_start) begin
      sdo_q <= rb_q[23];
    end else if (in_frame && sclk_rise && bitcnt_q != 6'h00) begin
      // First bit is presented at frame start; later bits on rising edges
      rb_q <= {rb_q[22:0], 1'b0}; // [RULE4] [RULE17]
      sdo_q <= rb_q[22];
    end
  end

  // Drive enable follows frame select and the disable bit
  logic oe_q;
  logic err_q;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      oe_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      oe_q <= ~sync_d & ~func_q[DDSC_FN_RDIS_POS]; // [RULE19]
      if (frame_end) err_q <= ~frame_ok; // [RULE16]
    end
  end

  assign o_serial_readback_out = sdo_q;
  assign o_serial_readback_oe = oe_q;
  assign o_chan_a = chan_q[0];
  assign o_chan_b = chan_q[1];
  assign o_dac_a = dac_q[0];
  assign o_dac_b = dac_q[1];
  assign o_func_ctrl = func_q;
  assign o_frame_error = err_q;
endmodule

// file: ddsc_pkg.sv
// Constants and carrier types for the dual converter serial command control.
// Assumes a single 100 MHz system clock; the shift link is sampled, not clocked.
package ddsc_pkg;
  localparam int unsigned DDSC_FRAME_BITS = 24;
  localparam int unsigned DDSC_DATA_W = 16;
  localparam int unsigned DDSC_SYNC_STAGES = 3;
  // Command word field positions
  localparam int unsigned DDSC_RW_POS = 23;
  localparam int unsigned DDSC_RSVD_POS = 22;
  localparam int unsigned DDSC_TGT_LSB = 19;
  localparam int unsigned DDSC_CHN_LSB = 16;
  // Target select codes
  localparam logic [2:0] DDSC_TGT_FUNC = 3'h0;
  localparam logic [2:0] DDSC_TGT_DATA = 3'h2;
  localparam logic [2:0] DDSC_TGT_CGAIN = 3'h3;
  localparam logic [2:0] DDSC_TGT_FGAIN = 3'h4;
  localparam logic [2:0] DDSC_TGT_OFFS = 3'h5;
  // Channel select codes, doubling as function-register sub-commands
  localparam logic [2:0] DDSC_CHN_A = 3'h0;
  localparam logic [2:0] DDSC_CHN_B = 3'h1;
  localparam logic [2:0] DDSC_CHN_BOTH = 3'h4;
  localparam logic [2:0] DDSC_FN_NOP = 3'h0;
  localparam logic [2:0] DDSC_FN_CTRL = 3'h1;
  localparam logic [2:0] DDSC_FN_CLEAR = 3'h4;
  localparam logic [2:0] DDSC_FN_LOAD = 3'h5;
  // Field widths and positions inside the 16 data bits
  localparam int unsigned DDSC_CG_W = 2;
  localparam int unsigned DDSC_FG_W = 6;
  localparam int unsigned DDSC_OFS_W = 8;
  localparam int unsigned DDSC_FN_W = 6;
  localparam int unsigned DDSC_FN_RDIS_POS = 0;
  // Reset values and clear codes
  localparam logic [15:0] DDSC_DATA_RST = 16'h0000;
  localparam logic [5:0] DDSC_FN_RST = 6'h00;
  localparam logic [15:0] DDSC_CLR_TWOS = 16'h0000;
  localparam logic [15:0] DDSC_CLR_BIN = 16'h0000;

  typedef struct packed {
    logic rd;
    logic rsvd;
    logic [2:0] tgt;
    logic [2:0] chn;
    logic [15:0] data;
  } ddsc_cmd_t;

  typedef struct packed {
    logic [15:0] data;
    logic [1:0] cgain;
    logic [5:0] fgain;
    logic [7:0] offs;
  } ddsc_chan_t;
endpackage

// file: ddsc_ctrl_checker.sv
// Port assertions for the dual converter command control.
// Assumes it is bound to ddsc_ctrl and sees only its ports.
`timescale 1ns/10ps
module ddsc_ctrl_checker #(
  parameter int unsigned FRAME_BITS = 24
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_shift_clk,
  input wire logic i_frame_sel_n,
  input wire logic i_shift_data_in,
  input wire logic i_output_load_n,
  input wire logic i_async_zero_n,
  input wire logic o_serial_readback_out,
  input wire logic o_serial_readback_oe,
  input wire ddsc_pkg::ddsc_chan_t o_chan_a,
  input wire ddsc_pkg::ddsc_chan_t o_chan_b,
  input wire logic [15:0] o_dac_a,
  input wire logic [15:0] o_dac_b,
  input wire logic [5:0] o_func_ctrl,
  input wire logic o_frame_error
);
  import ddsc_pkg::*;
  logic sc_q, fs_q, full;
  logic [4:0] cnt_q;
  logic [23:0] sh_q;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // Own copy of the word, so a decode slip cannot hide
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sc_q <= 1'b1;
      fs_q <= 1'b1;
      cnt_q <= 5'h00;
      sh_q <= 24'h000000;
    end else begin
      sc_q <= i_shift_clk;
      fs_q <= i_frame_sel_n;
      if (fs_q && !i_frame_sel_n) begin
        cnt_q <= 5'h00;
      end else if (sc_q && !i_shift_clk && !i_frame_sel_n) begin
        cnt_q <= cnt_q + 5'h01;
        sh_q <= {sh_q[22:0], i_shift_data_in};
      end
    end
  end
  assign full = 32'(cnt_q) == FRAME_BITS;
  chk_write_a_dac:
    assert property ($rose(i_frame_sel_n) && full && sh_q[23:16] == 8'h10 && !i_output_load_n
      |-> ##[1:8] o_dac_a == sh_q[15:0]) else $error("dac a not loaded");
  chk_read_no_write:
    assert property ($rose(i_frame_sel_n) && full && sh_q[23]
      |-> ##1 ($stable(o_chan_a) && $stable(o_chan_b))[*8]) else $error("read wrote");
  chk_frame_count:
    assert property ($rose(i_frame_sel_n) |-> ##8 o_frame_error == !full)
      else $error("frame error flag wrong");
  chk_readback_hold:
    assert property (!i_frame_sel_n && !$past(i_frame_sel_n, 8) && !i_shift_clk
      && !$past(i_shift_clk, 4) |-> $stable(o_serial_readback_out)) else $error("sdo moved");
  chk_readback_off:
    assert property (o_func_ctrl[0] && $past(o_func_ctrl[0]) |-> !o_serial_readback_oe)
      else $error("readback not disabled");
  chk_clear_zero:
    assert property ($fell(i_async_zero_n) |-> ##[1:8] (o_dac_a == 16'h0000
      && o_dac_b == 16'h0000)) else $error("clear missed");
  chk_load_all:
    assert property ($fell(i_output_load_n) && i_frame_sel_n |-> ##[1:8]
      (o_dac_a == o_chan_a.data && o_dac_b == o_chan_b.data)) else $error("load missed");
  chk_dac_quiet:
    assert property (!i_frame_sel_n && !$past(i_frame_sel_n, 8)
      |-> $stable(o_dac_a) && $stable(o_dac_b)) else $error("dac moved in frame");
endmodule

bind ddsc_ctrl ddsc_ctrl_checker #(.FRAME_BITS(FRAME_BITS)) chk (.*);

// file: ddsc_host_model.sv
// Host serial master model for the converter command link.
// Assumes the device takes bits on falling and drives on rising edges.
`timescale 1ns/10ps
module ddsc_host_model (
  output logic o_sclk,
  output logic o_fs_n,
  output logic o_sdi,
  input wire logic i_sdo
);
  initial begin
    o_sclk = 1'b1;
    o_fs_n = 1'b1;
    o_sdi = 1'b0;
  end
  // Clock stands high between frames; n other than 24 breaks the frame
  task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
    r = 24'h000000;
    o_fs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_sdi = w[23 - (i % 24)];
      #62.5 o_sclk = 1'b0;
      r = {r[22:0], i_sdo};
      #62.5 o_sclk = 1'b1;
    end
    #62.5 o_fs_n = 1'b1;
    o_sdi = ~o_sdi;
    #100;
  endtask
endmodule

// file: ddsc_ctrl_test.sv
// Self-checking bench for the dual converter command control.
// Assumes the host model drives the link and the checker is bound.
`timescale 1ns/10ps
module ddsc_ctrl_test;
  import ddsc_pkg::*;
  logic clk, rst_n, ld_n, zr_n, sclk, fs_n, sdi, serial_readback_out, ferr;
  ddsc_chan_t ca, cb;
  logic [15:0] da, db;
  logic [5:0] fn;
  logic [23:0] r;
  logic [23:0] wv [4] = '{24'h20002a, 24'h190002, 24'h2800c3, 24'h11abcd};
  logic [23:0] rv [4] = '{24'ha0ffff, 24'h990000, 24'ha80000, 24'h910000};
  int error_cnt = 0;
  int compares = 0;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ddsc_ctrl uut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_shift_clk(sclk), .i_frame_sel_n(fs_n),
    .i_shift_data_in(sdi), .i_output_load_n(ld_n), .i_async_zero_n(zr_n), .i_coding_select(1'b0),
    .o_serial_readback_out(serial_readback_out), .o_serial_readback_oe(), .o_chan_a(ca), .o_chan_b(cb),
    .o_dac_a(da), .o_dac_b(db), .o_func_ctrl(fn), .o_frame_error(ferr));
  ddsc_host_model host (.o_sclk(sclk), .o_fs_n(fs_n), .o_sdi(sdi), .i_sdo(serial_readback_out));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("mismatches %0d, comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tx(input logic [23:0] w, input int n = 24);
    host.xfer(w, n, r);
  endtask
  task automatic pins(input logic ld, input logic zr);
    @(posedge clk);
    #1 ld_n = ld;
    zr_n = zr;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    #500us;
    error_cnt++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    ld_n = 1'b0;
    zr_n = 1'b0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    pins(1'b0, 1'b1);
    cmp(da, 16'h0000);
    tx(24'h101234);
    cmp(da, 16'h1234);
    tx(24'h10ffff, 23);
    cmp({15'h0000, ferr}, 16'h0001);
    tx(24'h10ffff, 25);
    cmp(da, 16'h1234);
    pins(1'b1, 1'b1);
    tx(24'h11abcd);
    cmp(db, 16'h0000);
    pins(1'b0, 1'b1);
    cmp(db, 16'habcd);
    tx(24'h145555);
    tx(24'h125a5a);
    cmp(da, 16'h5555);
    cmp(db, 16'h5555);
    for (int i = 0; i < 4; i++) begin
      tx(wv[i]);
      tx(rv[i]);
      tx(24'h000000);
      cmp(r[15:0], wv[i][15:0]);
    end
    pins(1'b0, 1'b0);
    cmp(da, 16'h0000);
    pins(1'b0, 1'b1);
    cmp(db, 16'h0000);
    tx(24'h101111);
    tx(24'h040000);
    cmp(da, 16'h0000);
    tx(24'h010001);
    cmp({10'h000, fn}, 16'h0001);
    tx(24'ha00000);
    tx(24'h010000);
    test_done();
  end
endmodule
